// ===== hdl/bmc_controller.sv
// buck mode controller: mode selection and power switch sequencing
`timescale 1ns/1ps
module bmc_controller
  import bmc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PWM_PERIOD_CYCLES,
  parameter int unsigned MAX_ON_CYC = PWM_MAX_ON_CYCLES,
  parameter int unsigned ENTRY_CYC = PFM_ENTRY_CYCLES,
  parameter int unsigned STEP0_CYC = SS_STEP0_CYC,
  parameter int unsigned STEP1_CYC = SS_STEP1_CYC,
  parameter int unsigned STEP2_CYC = SS_STEP2_CYC,
  parameter int unsigned STEP3_CYC = SS_STEP3_CYC
) (
  // clock and enable-as-reset
  input wire logic clk,
  input wire logic resetn,
  // comparator flags
  input wire bmc_sense_t sense,
  input wire logic soft_limit_hit,
  // power switch gates
  output bmc_gate_t gate,
  // status
  output bmc_mode_t mode,
  output logic [9:0] inrush_limit_ma,
  output logic soft_start_done,
  output logic sleeping
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_PWM_HIGH,
    ST_PWM_LOW,
    ST_PFM_HIGH,
    ST_PFM_LOW,
    ST_PFM_SLEEP
  } bmc_state_t;

  bmc_state_t state_reg, state_next;
  logic [7:0] phase_reg, phase_next;
  logic [7:0] light_reg, light_next;
  bmc_gate_t gate_reg, gate_next;
  bmc_mode_t mode_reg, mode_next;
  logic [9:0] ilim_reg;
  logic done_reg, sleep_reg, sleep_next;
  logic [9:0] ss_ilim;
  logic ss_done;

  // ----------------------------------------------------------------
  // soft-start sequencer
  // ----------------------------------------------------------------
  bmc_soft_start #(
    .STEP0_CYC(STEP0_CYC),
    .STEP1_CYC(STEP1_CYC),
    .STEP2_CYC(STEP2_CYC),
    .STEP3_CYC(STEP3_CYC)
  ) u_ss (
    .clk(clk),
    .resetn(resetn),
    .ilim_ma(ss_ilim),
    .done(ss_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic cycle_start, over_limit;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    light_next = light_reg;
    cycle_start = (phase_reg == 8'(PERIOD_CYC - 1));
    // during soft-start the stepped limit also ends the on-time
    over_limit = sense.current_limit || (!ss_done && soft_limit_hit);
    if (state_reg == ST_PWM_HIGH || state_reg == ST_PWM_LOW) begin
      phase_next = cycle_start ? 8'h00 : phase_reg + 8'h01;
    end else begin
      phase_next = 8'h00;
    end
    case (state_reg)
      ST_OFF: begin
        state_next = ST_PWM_HIGH;
        light_next = 8'h00;
      end
      ST_PWM_HIGH: begin
        if (sense.dropout) begin
          state_next = ST_PWM_HIGH;
        end else if (over_limit || phase_reg >= 8'(MAX_ON_CYC - 1)) begin
          state_next = ST_PWM_LOW;
        end
      end
      ST_PWM_LOW: begin
        // dropout must not wait for the period end, or the high side misses cycles
        if (cycle_start || sense.dropout) begin
          state_next = ST_PWM_HIGH;
        end
      end
      ST_PFM_HIGH: begin
        if (sense.pfm_high || sense.pfm_peak_current_level) begin
          state_next = ST_PFM_LOW;
        end
      end
      ST_PFM_LOW: begin
        if (sense.zero_current) begin
          state_next = sense.pfm_high ? ST_PFM_SLEEP : ST_PFM_HIGH;
        end
      end
      ST_PFM_SLEEP: begin
        if (sense.pfm_low) begin
          state_next = ST_PFM_HIGH;
        end
      end
      default: state_next = ST_OFF;
    endcase
    // light-load qualification only counts while switching in PWM
    if (state_reg == ST_PWM_HIGH || state_reg == ST_PWM_LOW) begin
      if ((sense.discontinuous || sense.below_mode_level) && ss_done && !sense.dropout) begin
        if (light_reg + 8'h01 >= 8'(ENTRY_CYC)) begin
          state_next = ST_PFM_HIGH;
          light_next = 8'h00;
        end else begin
          light_next = light_reg + 8'h01;
        end
      end else begin
        light_next = 8'h00;
      end
    end else begin
      light_next = 8'h00;
    end
    if ((state_reg == ST_PFM_HIGH || state_reg == ST_PFM_LOW || state_reg == ST_PFM_SLEEP)
        && sense.pwm_return_threshold) begin
      state_next = ST_PWM_HIGH;
      phase_next = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs decoded from next state
  // ----------------------------------------------------------------
  always_comb begin
    gate_next = '0;
    mode_next = BMC_MODE_PWM;
    sleep_next = 1'b0;
    case (state_next)
      ST_OFF: mode_next = BMC_MODE_SHUTDOWN;
      ST_PWM_HIGH: gate_next.high_side_switch = 1'b1;
      ST_PWM_LOW: gate_next.low_side_switch = 1'b1;
      ST_PFM_HIGH: begin
        gate_next.high_side_switch = 1'b1;
        mode_next = BMC_MODE_PFM;
      end
      ST_PFM_LOW: begin
        gate_next.low_side_switch = 1'b1;
        mode_next = BMC_MODE_PFM;
      end
      ST_PFM_SLEEP: begin
        mode_next = BMC_MODE_PFM;
        sleep_next = 1'b1;
      end
      default: mode_next = BMC_MODE_SHUTDOWN;
    endcase
  end

  // ----------------------------------------------------------------
  // registers; resetn is the enable pin, low means shutdown
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
      phase_reg <= 8'h00;
      light_reg <= 8'h00;
      gate_reg <= '0;
      mode_reg <= BMC_MODE_SHUTDOWN;
      ilim_reg <= ILIM_ZERO_MA;
      done_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      light_reg <= light_next;
      gate_reg <= gate_next;
      mode_reg <= mode_next;
      ilim_reg <= ss_ilim;
      done_reg <= ss_done;
      sleep_reg <= sleep_next;
    end
  end

  assign gate = gate_reg;
  assign mode = mode_reg;
  assign inrush_limit_ma = ilim_reg;
  assign soft_start_done = done_reg;
  assign sleeping = sleep_reg;

endmodule : bmc_controller

// ===== hdl/bmc_pkg.sv
// package: constants, types and timing for the buck mode controller
package bmc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PWM_PERIOD_CYCLES = 10;
  localparam int unsigned PWM_MAX_ON_CYCLES = 8;
  localparam int unsigned PFM_ENTRY_CYCLES = 32;
  localparam int unsigned SS_STEP0_US = 32;
  localparam int unsigned SS_STEP1_US = 224;
  localparam int unsigned SS_STEP2_US = 256;
  localparam int unsigned SS_STEP3_US = 256;
  localparam int unsigned SS_STEP0_CYC = (SS_STEP0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP1_CYC = (SS_STEP1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP2_CYC = (SS_STEP2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP3_CYC = (SS_STEP3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // inrush limit levels in mA
  // ----------------------------------------------------------------
  localparam logic [9:0] ILIM_ZERO_MA = 10'h000;
  localparam logic [9:0] ILIM_STEP1_MA = 10'h046;
  localparam logic [9:0] ILIM_STEP2_MA = 10'h08C;
  localparam logic [9:0] ILIM_STEP3_MA = 10'h118;
  localparam logic [9:0] ILIM_FULL_MA = 10'h26C;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BMC_MODE_SHUTDOWN,
    BMC_MODE_PWM,
    BMC_MODE_PFM
  } bmc_mode_t;

  typedef struct packed {
    logic pfm_high;
    logic pfm_low;
    logic pwm_return_threshold;
    logic pfm_peak_current_level;
    logic peak_current;
    logic current_limit;
    logic zero_current;
    logic discontinuous;
    logic below_mode_level;
    logic dropout;
  } bmc_sense_t;

  typedef struct packed {
    logic high_side_switch;
    logic low_side_switch;
  } bmc_gate_t;

endpackage : bmc_pkg

// ===== hdl/bmc_soft_start.sv
// soft-start inrush limit sequencer
`timescale 1ns/1ps
module bmc_soft_start
  import bmc_pkg::*;
#(
  parameter int unsigned STEP0_CYC = SS_STEP0_CYC,
  parameter int unsigned STEP1_CYC = SS_STEP1_CYC,
  parameter int unsigned STEP2_CYC = SS_STEP2_CYC,
  parameter int unsigned STEP3_CYC = SS_STEP3_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // status
  output logic [9:0] ilim_ma,
  output logic done
);

  logic [2:0] step_reg, step_next;
  logic [12:0] cnt_reg, cnt_next;
  logic [9:0] ilim_reg, ilim_next;

  function automatic logic [12:0] step_len(input logic [2:0] s);
    case (s)
      3'h0: step_len = 13'(STEP0_CYC);
      3'h1: step_len = 13'(STEP1_CYC);
      3'h2: step_len = 13'(STEP2_CYC);
      default: step_len = 13'(STEP3_CYC);
    endcase
  endfunction : step_len

  always_comb begin
    step_next = step_reg;
    cnt_next = cnt_reg;
    if (step_reg < 3'h4) begin
      if (cnt_reg + 13'h0001 >= step_len(step_reg)) begin
        step_next = step_reg + 3'h1;
        cnt_next = 13'h0000;
      end else begin
        cnt_next = cnt_reg + 13'h0001;
      end
    end
    case (step_next)
      3'h0: ilim_next = ILIM_ZERO_MA;
      3'h1: ilim_next = ILIM_STEP1_MA;
      3'h2: ilim_next = ILIM_STEP2_MA;
      3'h3: ilim_next = ILIM_STEP3_MA;
      default: ilim_next = ILIM_FULL_MA;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      step_reg <= 3'h0;
      cnt_reg <= 13'h0000;
      ilim_reg <= ILIM_ZERO_MA;
    end else begin
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      ilim_reg <= ilim_next;
    end
  end

  assign ilim_ma = ilim_reg;
  assign done = (step_reg == 3'h4);

endmodule : bmc_soft_start

// ===== tb/bmc_monitor.sv
// checker: port-level properties of the buck mode controller
`timescale 1ns/1ps
module bmc_monitor
  import bmc_pkg::*;
#(
  parameter int unsigned ENTRY_CYC = PFM_ENTRY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // comparator inputs
  input wire bmc_sense_t sense,
  input wire logic soft_limit_hit,
  // controller outputs
  input wire bmc_gate_t gate,
  input wire bmc_mode_t mode,
  input wire logic [9:0] inrush_limit_ma,
  input wire logic soft_start_done,
  input wire logic sleeping
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // light-load run length
  // ----------------------------------------------------------------
  int unsigned light_reg;
  int unsigned light_next;
  always_comb begin
    light_next = 0;
    if (mode == BMC_MODE_PWM && soft_start_done && !sense.dropout && (sense.discontinuous || sense.below_mode_level)) begin
      light_next = light_reg + 1;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      light_reg <= 0;
    end else begin
      light_reg <= light_next;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_no_overlap: assert property (!(gate.high_side_switch && gate.low_side_switch)) else $error("both switches on");
  chk_mode_legal: assert property (mode inside {BMC_MODE_SHUTDOWN, BMC_MODE_PWM, BMC_MODE_PFM}) else $error("bad mode");
  chk_limit_cut: assert property (mode == BMC_MODE_PWM && sense.current_limit && !sense.dropout && gate.high_side_switch
    |=> !gate.high_side_switch) else $error("limit did not end on-time");
  chk_dropout_hold: assert property (mode == BMC_MODE_PWM && sense.dropout && !sense.current_limit && !soft_limit_hit
    |=> gate.high_side_switch) else $error("dropout not held on");
  chk_entry_early: assert property (mode == BMC_MODE_PFM && $past(mode) == BMC_MODE_PWM |-> $past(light_reg) >= ENTRY_CYC - 2)
    else $error("pfm entered early");
  chk_entry_late: assert property (light_reg <= ENTRY_CYC + 3) else $error("pfm entry missed");
  chk_pfm_peak: assert property (mode == BMC_MODE_PFM && gate.high_side_switch && !sense.pwm_return_threshold &&
    (sense.pfm_high || sense.pfm_peak_current_level) |=> !gate.high_side_switch) else $error("pfm pulse not ended");
  chk_zero_off: assert property (mode == BMC_MODE_PFM && gate.low_side_switch && sense.zero_current &&
    !sense.pwm_return_threshold |=> !gate.low_side_switch) else $error("low side kept past zero");
  chk_sleep_off: assert property (sleeping |-> gate == 2'h0 && mode == BMC_MODE_PFM) else $error("switch on in sleep");
  chk_sleep_wake: assert property (sleeping && sense.pfm_low && !sense.pwm_return_threshold
    |=> !sleeping ##0 gate.high_side_switch) else $error("no wake on low threshold");
  chk_pwm_return: assert property (mode == BMC_MODE_PFM && sense.pwm_return_threshold |=> mode == BMC_MODE_PWM)
    else $error("no return to pwm");
  chk_inrush_rise: assert property ($past(resetn) && $changed(inrush_limit_ma) |-> inrush_limit_ma > $past(inrush_limit_ma))
    else $error("inrush limit fell");
  chk_done_full: assert property (soft_start_done |-> inrush_limit_ma == ILIM_FULL_MA) else $error("done below full");
  cover property (sleeping);
  cover property (sense.current_limit && gate.high_side_switch);
  cover property (soft_start_done && sense.dropout);
endmodule : bmc_monitor

bind bmc_controller bmc_monitor #(.ENTRY_CYC(ENTRY_CYC)) u_mon (.clk, .resetn, .sense, .soft_limit_hit, .gate, .mode,
  .inrush_limit_ma, .soft_start_done, .sleeping);

// ===== tb/bmc_plant.sv
// partner model: inductor current as seen by the comparators
`timescale 1ns/1ps
module bmc_plant
  import bmc_pkg::*;
#(
  parameter int PFM_PK = 4,
  parameter int LIM_PK = 12
) (
  // clock and switches
  input wire logic clk,
  input wire bmc_gate_t gate,
  input wire logic overload,
  // comparator flags
  output logic zero_current,
  output logic pfm_peak,
  output logic current_limit
);
  int il = 0;
  // clamp at 8 unless overloaded, so a normal period never trips the limit
  always @(posedge clk) begin
    if (gate.high_side_switch) begin
      il <= overload ? il + 4 : (il < 8 ? il + 1 : 8);
    end else if (gate.low_side_switch) begin
      il <= (il > 4) ? il - 4 : 0;
    end
  end
  assign zero_current = (il == 0);
  assign pfm_peak = (il >= PFM_PK);
  assign current_limit = (il >= LIM_PK);
endmodule : bmc_plant

// ===== tb/testbench.sv
// testbench: directed scenarios for the buck mode controller
`timescale 1ns/1ps
module testbench;
  import bmc_pkg::*;
  localparam int unsigned STEP = 8;
  logic clk = 0;
  logic resetn = 0;
  logic overload = 0;
  logic soft_limit_hit = 0;
  logic pfm_high = 0, pfm_low = 0, ret = 0, disc = 0, dropout = 0;
  logic zero_current, pfm_peak, current_limit, soft_start_done, sleeping;
  logic [9:0] inrush_limit_ma;
  bmc_sense_t sense;
  bmc_gate_t gate;
  bmc_mode_t mode;
  int failures = 0;
  int checks = 0;
  int hi, lo;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  assign sense = '{pfm_high, pfm_low, ret, pfm_peak, 1'b0, current_limit, zero_current, disc, 1'b0, dropout};
  bmc_controller #(.STEP0_CYC(STEP), .STEP1_CYC(STEP), .STEP2_CYC(STEP), .STEP3_CYC(STEP)) u_dut (.clk(clk),
    .resetn(resetn), .sense(sense), .soft_limit_hit(soft_limit_hit), .gate(gate), .mode(mode),
    .inrush_limit_ma(inrush_limit_ma), .soft_start_done(soft_start_done), .sleeping(sleeping));
  bmc_plant u_plant (.clk(clk), .gate(gate), .overload(overload), .zero_current(zero_current), .pfm_peak(pfm_peak),
    .current_limit(current_limit));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic count_period;
    hi = 0;
    lo = 0;
    repeat (PWM_PERIOD_CYCLES) begin
      @(negedge clk);
      hi += (gate.high_side_switch === 1'b1);
      lo += (gate.low_side_switch === 1'b1);
    end
  endtask : count_period
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_start;
    logic [9:0] lvl [4] = '{ILIM_ZERO_MA, ILIM_STEP1_MA, ILIM_STEP2_MA, ILIM_STEP3_MA};
    check("gate_in_reset", gate, 2'h0);
    check("mode_in_reset", mode, BMC_MODE_SHUTDOWN);
    resetn = 1;
    cyc(2);
    check("mode_enabled", mode, BMC_MODE_PWM);
    cyc(3);
    for (int i = 0; i < 4; i++) begin
      check("inrush_step", inrush_limit_ma, lvl[i]);
      cyc(STEP);
    end
    cyc(STEP);
    check("inrush_full", inrush_limit_ma, ILIM_FULL_MA);
    check("ss_done", soft_start_done, 1'b1);
    $display("t_start finished");
  endtask : t_start
  task automatic t_pwm;
    count_period();
    check("pwm_high", hi, PWM_MAX_ON_CYCLES);
    check("pwm_low", lo, PWM_PERIOD_CYCLES - PWM_MAX_ON_CYCLES);
    overload = 1;
    cyc(PWM_PERIOD_CYCLES);
    count_period();
    check("limit_cut", hi < PWM_MAX_ON_CYCLES, 1'b1);
    overload = 0;
    cyc(2 * PWM_PERIOD_CYCLES);
    count_period();
    check("limit_resume", hi, PWM_MAX_ON_CYCLES);
    dropout = 1;
    cyc(3);
    count_period();
    check("dropout_on", hi, PWM_PERIOD_CYCLES);
    dropout = 0;
    cyc(PWM_PERIOD_CYCLES);
    $display("t_pwm finished");
  endtask : t_pwm
  task automatic t_pfm;
    disc = 1;
    cyc(20);
    check("pwm_before_entry", mode, BMC_MODE_PWM);
    cyc(17);
    check("pfm_entered", mode, BMC_MODE_PFM);
    count_period();
    check("pfm_pulses", hi > 0 && lo > 0, 1'b1);
    pfm_high = 1;
    for (int i = 0; i < 20 && sleeping !== 1'b1; i++) cyc(1);
    check("sleep_gates", {sleeping, gate}, 3'h4);
    pfm_high = 0;
    cyc(3);
    check("sleep_holds", sleeping, 1'b1);
    pfm_low = 1;
    cyc(2);
    check("wake_pulse", gate.high_side_switch, 1'b1);
    pfm_low = 0;
    disc = 0;
    ret = 1;
    cyc(2);
    check("pwm_return", mode, BMC_MODE_PWM);
    ret = 0;
    $display("t_pfm finished");
  endtask : t_pfm
  task automatic t_restart;
    resetn = 0;
    cyc(2);
    check("gate_shutdown", gate, 2'h0);
    check("mode_shutdown", mode, BMC_MODE_SHUTDOWN);
    check("sleep_shutdown", sleeping, 1'b0);
    resetn = 1;
    cyc(2);
    check("restart_high", gate, 2'h2);
    soft_limit_hit = 1;
    cyc(2);
    check("soft_limit_cut", gate, 2'h1);
    soft_limit_hit = 0;
    disc = 1;
    cyc(34);
    check("no_entry_in_ss", mode, BMC_MODE_PWM);
    disc = 0;
    $display("t_restart finished");
  endtask : t_restart
  initial begin
    cyc(3);
    t_start();
    t_pwm();
    t_pfm();
    t_restart();
    final_report();
  end
  initial begin
    #(3000 * CLK_PERIOD_NS);
    failures++;
    final_report();
  end
endmodule : testbench
